/* rtl/bcr_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// R01: Enable 0 releases both lines, inputs still sampled.
// R02: Receive-data read restarts reception only when hold bit is 0.
// R03: Mode pair 00 SR, 01 ST, 10 MR, 11 MT.
// R04: Arbitration loss in bus master mode clears master and transmit.
// R05: Software changes transmit bit only between frames.
// R06: Address match with eighth bit 1 sets transmit bit.
// R07: Overrun in synchronous master receive clears master bit.
// R08: Synchronous format with master drives transfer clock out.
// R09: Clock select divides by 28..128 and 112..512 table.
// R10: Control one resets to 0x00.
// R11: Control two resets to 0x7D.
// R12: Data falling while clock high sets bus-occupied.
// R13: Data rising while clock high clears bus-occupied.
// R14: Synchronous format reads bus-occupied as 0.
// R15: Write busy 1 guard 0 issues start or repeated start.
// R16: Write busy 0 guard 0 issues stop.
// R17: Guard bit reads 1 and is never stored.
// R18: Data drive value written only with protect 0.
// R19: Data drive value reads output level; protect reads 1.
// R20: Software leaves data drive value alone during transfers.
// R21: Clock level bit reports clock output level.
// R22: Bits 2 and 0 of control two read 1.
// R23: Control-part reset clears counter and internal control.
// R24: Control-part reset forces transfer bit counter to zero.
// R25: Master clock has even phases and stretches when held low.
module bcr_ctrl
  import bcr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sync_format,
  input wire logic arb_lost,
  input wire logic addr_match_read,
  input wire logic overrun,
  input wire logic rx_data_read,
  input wire logic frame_active,
  input wire logic engine_scl_low,
  input wire logic engine_sda_low,
  output logic rx_start,
  output logic ctrl_reset,
  output logic [2:0] transfer_bit_counter,
  output logic [3:0] mode_out,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  typedef struct packed {
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] one;
    logic busy;
    logic sda_val;
    logic crst;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    bcr_cond_t cond;
    logic cond_start;
    logic [7:0] tcnt;
    logic rx_start;
    logic [2:0] bitcnt;
    bcr_pins_t pins;
  } bcr_state_t;

  bcr_state_t st_ff;
  bcr_state_t nxt_st;
  logic div_low;
  logic master_clk_run;
  logic scl_s;
  logic sda_s;
  logic scl_level;
  logic [7:0] two_rd;
  logic wr_fire;

  assign scl_s = st_ff.scl_sync[1];
  assign sda_s = st_ff.sda_sync[1];
  assign master_clk_run = st_ff.one[BCR_B_ENABLE] & st_ff.one[BCR_B_MST]
    & (sync_format | frame_active);

  bcr_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(master_clk_run),
    .sel(st_ff.one[3:0]),
    .scl_in(scl_s),
    .scl_low(div_low)
  );

  // R21 clock output level
  assign scl_level = ~(st_ff.pins.scl_oe & ~st_ff.pins.scl_o);
  assign wr_fire = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;

  always_comb begin
    two_rd = BCR_RST_TWO;
    // R14 sync format reads 0
    two_rd[BCR_B_BUSY] = st_ff.busy & ~sync_format;
    // R17 guard reads one
    two_rd[BCR_B_GUARD] = 1'b1;
    // R19 drive level readback
    two_rd[BCR_B_SDAV] = ~(st_ff.pins.sda_oe & ~st_ff.pins.sda_o);
    two_rd[BCR_B_SDAP] = 1'b1;
    two_rd[BCR_B_CLOCK_LINE_LEVEL] = scl_level;
    two_rd[BCR_B_CRST] = st_ff.crst;
    // R22 reserved bits one
    two_rd[2] = 1'b1;
    two_rd[0] = 1'b1;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rx_start = 1'b0;
    nxt_st.scl_sync = {st_ff.scl_sync[0], scl_i};
    nxt_st.sda_sync = {st_ff.sda_sync[0], sda_i};
    nxt_st.scl_prev = scl_s;
    nxt_st.sda_prev = sda_s;
    // AXI write channels
    if (s_axi_awvalid && !st_ff.aw_got) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_got) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // R12 start seen sets busy
    if (!sync_format && scl_s && st_ff.scl_prev && st_ff.sda_prev && !sda_s) begin
      nxt_st.busy = 1'b1;
    end
    // R13 stop seen clears busy
    if (!sync_format && scl_s && st_ff.scl_prev && !st_ff.sda_prev && sda_s) begin
      nxt_st.busy = 1'b0;
    end
    if (wr_fire) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = BCR_RESP_OKAY;
      if (st_ff.aw_addr == BCR_ADDR_ONE) begin
        if (st_ff.w_strb[0]) begin
          nxt_st.one = st_ff.w_data[7:0];
        end
      end else if (st_ff.aw_addr == BCR_ADDR_TWO) begin
        if (st_ff.w_strb[0]) begin
          nxt_st.crst = st_ff.w_data[BCR_B_CRST];
          // R18 protected drive write
          if (!st_ff.w_data[BCR_B_SDAP]) begin
            nxt_st.sda_val = st_ff.w_data[BCR_B_SDAV];
          end
          // R15 R16 condition issue
          if (!st_ff.w_data[BCR_B_GUARD] && st_ff.one[BCR_B_MST] && !sync_format) begin
            nxt_st.cond = BCR_C_SETUP;
            nxt_st.cond_start = st_ff.w_data[BCR_B_BUSY];
            nxt_st.tcnt = 8'h00;
          end
        end
      end else if (st_ff.aw_addr == BCR_ADDR_EVT) begin
        nxt_st.bresp = BCR_RESP_OKAY;
      end else begin
        nxt_st.bresp = BCR_RESP_SLVERR;
      end
    end
    // R04 arbitration loss
    if (arb_lost && !sync_format && st_ff.one[BCR_B_MST]) begin
      nxt_st.one[BCR_B_MST] = 1'b0;
      nxt_st.one[BCR_B_TRS] = 1'b0;
      nxt_st.cond = BCR_C_IDLE;
    end
    // R06 read address match
    if (addr_match_read && !st_ff.one[BCR_B_MST] && !st_ff.one[BCR_B_TRS]) begin
      nxt_st.one[BCR_B_TRS] = 1'b1;
    end
    // R07 overrun leaves master
    if (overrun && sync_format && st_ff.one[BCR_B_MST] && !st_ff.one[BCR_B_TRS]) begin
      nxt_st.one[BCR_B_MST] = 1'b0;
    end
    // R02 next reception gate
    if (rx_data_read && !st_ff.one[BCR_B_TRS] && !st_ff.one[BCR_B_RHOLD]) begin
      nxt_st.rx_start = 1'b1;
    end
    // Condition sequencer
    case (st_ff.cond)
      // Idle keeps a sequence armed by a write above
      BCR_C_IDLE: begin
      end
      BCR_C_SETUP: begin
        nxt_st.tcnt = st_ff.tcnt + 8'h01;
        if (st_ff.tcnt == 8'(BCR_COND_CYC - 1)) begin
          nxt_st.cond = BCR_C_SDA;
          nxt_st.tcnt = 8'h00;
        end
      end
      BCR_C_SDA: begin
        nxt_st.tcnt = st_ff.tcnt + 8'h01;
        if (st_ff.tcnt == 8'(BCR_COND_CYC - 1)) begin
          nxt_st.cond = BCR_C_SCL;
          nxt_st.tcnt = 8'h00;
        end
      end
      BCR_C_SCL: begin
        nxt_st.cond = BCR_C_DONE;
      end
      BCR_C_DONE: begin
        nxt_st.cond = BCR_C_IDLE;
      end
      default: begin
        nxt_st.cond = BCR_C_IDLE;
      end
    endcase
    // Bit counter holds its value; only the control-part reset below loads it
    nxt_st.bitcnt = st_ff.bitcnt;
    // R23 R24 control-part reset
    if (st_ff.crst) begin
      nxt_st.bitcnt = BCR_BITCNT_RST;
      nxt_st.cond = BCR_C_IDLE;
      nxt_st.tcnt = 8'h00;
      nxt_st.rx_start = 1'b0;
    end
    // Pin drive
    nxt_st.pins.scl_o = 1'b0;
    nxt_st.pins.sda_o = 1'b0;
    nxt_st.pins.sda_oe = ~st_ff.sda_val | engine_sda_low;
    nxt_st.pins.scl_oe = engine_scl_low;
    if (st_ff.cond == BCR_C_SDA) begin
      // Start: data low first; stop: data held low until release
      nxt_st.pins.sda_oe = st_ff.cond_start;
    end else if (st_ff.cond == BCR_C_SETUP) begin
      nxt_st.pins.sda_oe = ~st_ff.cond_start;
    end
    // Start ends with clock low, so data release is no stop
    if ((st_ff.cond == BCR_C_SCL || st_ff.cond == BCR_C_DONE) && st_ff.cond_start) begin
      nxt_st.pins.scl_oe = 1'b1;
      nxt_st.pins.sda_oe = 1'b1;
    end
    // R08 master clock out
    if (master_clk_run && div_low) begin
      nxt_st.pins.scl_oe = 1'b1;
    end
    // R01 disabled releases lines
    if (!st_ff.one[BCR_B_ENABLE]) begin
      nxt_st.pins.scl_oe = 1'b0;
      nxt_st.pins.sda_oe = 1'b0;
    end
    // AXI read channel
    nxt_st.arready = 1'b0;
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.rvalid && !st_ff.arready) begin
      nxt_st.arready = 1'b1;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = BCR_RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      if (s_axi_araddr == BCR_ADDR_ONE) begin
        nxt_st.rdata[7:0] = st_ff.one;
      end else if (s_axi_araddr == BCR_ADDR_TWO) begin
        nxt_st.rdata[7:0] = two_rd;
      end else if (s_axi_araddr == BCR_ADDR_EVT) begin
        nxt_st.rdata[3:0] = {st_ff.cond != BCR_C_IDLE, st_ff.bitcnt};
      end else begin
        nxt_st.rresp = BCR_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      // R10 control one reset
      st_ff.one <= BCR_RST_ONE;
      // R11 control two reset
      st_ff.sda_val <= BCR_RST_TWO[BCR_B_SDAV];
      st_ff.crst <= BCR_RST_TWO[BCR_B_CRST];
      st_ff.scl_sync <= 2'h3;
      st_ff.sda_sync <= 2'h3;
      st_ff.scl_prev <= 1'b1;
      st_ff.sda_prev <= 1'b1;
      st_ff.cond <= BCR_C_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = ~st_ff.aw_got;
  assign s_axi_wready = ~st_ff.w_got;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign rx_start = st_ff.rx_start;
  assign ctrl_reset = st_ff.crst;
  assign transfer_bit_counter = st_ff.bitcnt;
  // R03 mode decode out
  assign mode_out = {st_ff.one[BCR_B_MST] & st_ff.one[BCR_B_TRS],
    st_ff.one[BCR_B_MST] & ~st_ff.one[BCR_B_TRS],
    ~st_ff.one[BCR_B_MST] & st_ff.one[BCR_B_TRS],
    ~st_ff.one[BCR_B_MST] & ~st_ff.one[BCR_B_TRS]};
  assign scl_o = st_ff.pins.scl_o;
  assign scl_oe = st_ff.pins.scl_oe;
  assign sda_o = st_ff.pins.sda_o;
  assign sda_oe = st_ff.pins.sda_oe;
endmodule

/* common/bcr_pkg.sv */
package bcr_pkg;
  // AXI4-Lite register byte addresses
  localparam logic [3:0] BCR_ADDR_ONE = 4'h0;
  localparam logic [3:0] BCR_ADDR_TWO = 4'h4;
  localparam logic [3:0] BCR_ADDR_EVT = 4'h8;
  localparam logic [7:0] BCR_RST_ONE = 8'h00;
  localparam logic [7:0] BCR_RST_TWO = 8'h7D;
  // Control one field positions
  localparam int BCR_B_ENABLE = 7;
  localparam int BCR_B_RHOLD = 6;
  localparam int BCR_B_MST = 5;
  localparam int BCR_B_TRS = 4;
  // Control two field positions
  localparam int BCR_B_BUSY = 7;
  localparam int BCR_B_GUARD = 6;
  localparam int BCR_B_SDAV = 5;
  localparam int BCR_B_SDAP = 4;
  localparam int BCR_B_CLOCK_LINE_LEVEL = 3;
  localparam int BCR_B_CRST = 1;
  localparam logic [1:0] BCR_RESP_OKAY = 2'h0;
  localparam logic [1:0] BCR_RESP_SLVERR = 2'h2;
  localparam logic [2:0] BCR_BITCNT_RST = 3'h0;
  // Cycles from clock release until the synced pin echoes high
  localparam logic [9:0] BCR_SCL_SYNC_CYC = 10'h003;
  localparam int BCR_CLK_MHZ = 100;
  // Start/stop setup/hold figure in ns
  localparam int BCR_COND_NS = 600;
  localparam int BCR_COND_CYC = (BCR_COND_NS * BCR_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    BCR_C_IDLE = 3'h0,
    BCR_C_SETUP = 3'h1,
    BCR_C_SDA = 3'h3,
    BCR_C_SCL = 3'h2,
    BCR_C_DONE = 3'h6
  } bcr_cond_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } bcr_pins_t;
endpackage

/* rtl/bcr_divider.sv */
`timescale 1ns/1ps
module bcr_divider
  import bcr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [3:0] sel,
  input wire logic scl_in,
  output logic scl_low
);
  typedef struct packed {
    logic [9:0] cnt;
    logic low;
  } bcr_div_state_t;
  bcr_div_state_t st_ff;
  bcr_div_state_t nxt_st;
  logic [9:0] half;

  // R09 divider ratio table
  always_comb begin
    case (sel)
      4'h0: half = 10'd14;
      4'h1: half = 10'd20;
      4'h2: half = 10'd24;
      4'h3: half = 10'd32;
      4'h4: half = 10'd40;
      4'h5: half = 10'd50;
      4'h6: half = 10'd56;
      4'h7: half = 10'd64;
      4'h8: half = 10'd56;
      4'h9: half = 10'd80;
      4'hA: half = 10'd96;
      4'hB: half = 10'd128;
      4'hC: half = 10'd160;
      4'hD: half = 10'd200;
      4'hE: half = 10'd224;
      default: half = 10'd256;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    if (!run) begin
      nxt_st.cnt = 10'h000;
      nxt_st.low = 1'b0;
    // R25 even phases, stretch
    end else if (!st_ff.low && !scl_in && st_ff.cnt >= BCR_SCL_SYNC_CYC) begin
      nxt_st.cnt = st_ff.cnt;
    end else if (st_ff.cnt + 10'd1 >= half) begin
      nxt_st.cnt = 10'h000;
      nxt_st.low = ~st_ff.low;
    end else begin
      nxt_st.cnt = st_ff.cnt + 10'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign scl_low = st_ff.low;
endmodule

/* verification/bcr_ctrl_asserts.sv */
`timescale 1ns/1ps
module bcr_ctrl_asserts
  import bcr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic rx_data_read,
  input wire logic rx_start,
  input wire logic ctrl_reset,
  input wire logic [2:0] transfer_bit_counter,
  input wire logic [3:0] mode_out,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  AST_AR_PAIR: assert property (s_axi_arready |-> s_axi_rvalid && $past(s_axi_arvalid))
    else $error("arready without answer");
  AST_MODE_HOT: assert property ($onehot(mode_out))
    else $error("mode not one-hot");
  AST_RX_CAUSE: assert property (rx_start |-> $past(rx_data_read) && $past(mode_out[0] | mode_out[2]))
    else $error("reception start without cause");
  AST_CRST_CNT: assert property (ctrl_reset ##1 ctrl_reset |-> transfer_bit_counter == 3'h0)
    else $error("bit counter not cleared");
  AST_RST_FREE: assert property ($rose(aresetn) |-> !scl_oe && !sda_oe)
    else $error("lines driven after reset");
endmodule

/* verification/bcr_bus_dev.sv */
`timescale 1ns/1ps
module bcr_bus_dev (
  input wire logic aclk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic [1:0] cond,
  output logic scl_i,
  output logic sda_i
);
  logic sda_low_ff = 1'b0;
  assign scl_i = !scl_oe;
  assign sda_i = !(sda_oe || sda_low_ff);
  always @(posedge aclk) begin
    if (cond == 2'h1) sda_low_ff <= 1'b1;
    if (cond == 2'h2) sda_low_ff <= 1'b0;
  end
endmodule

/* verification/bcr_ctrl_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
`define END(s) $display("test %s done", s);
module bcr_ctrl_bench
  import bcr_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF, mode_out, k;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, sync_format = 0, frame_active = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, cond = '0, r;
  logic engine_scl_low = 0, engine_sda_low = 0, rx_start, ctrl_reset;
  logic scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  logic [2:0] transfer_bit_counter;
  logic [3:0] ev = '0;
  logic [7:0] v, w;
  logic [11:0] c;
  wire arb_lost, addr_match_read, overrun, rx_data_read;
  int checked = 0, bad_count = 0, seed = 68, n;
  assign {arb_lost, addr_match_read, overrun, rx_data_read} = ev;
  always #5 aclk = ~aclk;
  bcr_ctrl DUT (.*);
  bcr_bus_dev dev (.*);
  function automatic logic [7:0] two(input logic b, input logic s);
    return {b, 1'b1, s, 5'h1D};
  endfunction
  function automatic int div(input logic [3:0] s);
    int t[8] = '{28, 40, 48, 64, 80, 100, 112, 128};
    return s[3] ? t[s[2:0]] * 4 : t[s[2:0]];
  endfunction
  task results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task tmo;
    bad_count++;
    results();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) tmo();
    repeat (2) @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a);
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    v = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) tmo();
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    `CHK("reg", e, v & m)
  endtask
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev <= '0;
    @(posedge aclk);
  endtask
  task automatic cnd(input logic [1:0] x);
    repeat (4) @(posedge aclk);
    cond <= x;
    @(posedge aclk);
    cond <= 2'h0;
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(BCR_ADDR_ONE, 8'hFF, BCR_RST_ONE);
    rc(BCR_ADDR_TWO, 8'hFF, two(0, 1));
    rd(4'hC);
    `CHK("rresp", BCR_RESP_SLVERR, r)
    wr(4'hC, 8'hFF);
    `CHK("bresp", BCR_RESP_SLVERR, r)
    `END("reset")
    // Mode changes only with no frame running
    for (int m = 0; m < 4; m++) begin
      w = {2'h2, 2'(m), 4'($random(seed))};
      wr(BCR_ADDR_ONE, w);
      `CHK("mode", 4'h1 << m, mode_out)
      rc(BCR_ADDR_ONE, 8'hFF, w);
    end
    for (int h = 0; h < 2; h++) begin
      wr(BCR_ADDR_ONE, {1'b1, 1'(h), 6'h0});
      pulse(0);
      c = 12'(rx_start);
      repeat (4) begin
        @(posedge aclk);
        c += rx_start;
      end
      `CHK("rx_start", 12'(1 - h), c)
    end
    wr(BCR_ADDR_ONE, 8'hB0);
    pulse(3);
    `CHK("mode", 4'h1, mode_out)
    rc(BCR_ADDR_ONE, 8'h30, 8'h00);
    pulse(2);
    `CHK("mode", 4'h2, mode_out)
    sync_format <= 1'b1;
    wr(BCR_ADDR_ONE, 8'hA0);
    pulse(1);
    `CHK("mode", 4'h1, mode_out)
    sync_format <= 1'b0;
    `END("mode")
    cnd(2'h1);
    rc(BCR_ADDR_TWO, 8'h80, 8'h80);
    sync_format <= 1'b1;
    rc(BCR_ADDR_TWO, 8'h80, 8'h00);
    sync_format <= 1'b0;
    cnd(2'h2);
    rc(BCR_ADDR_TWO, 8'h80, 8'h00);
    `END("busy")
    // Drive value touched between transfers only
    wr(BCR_ADDR_TWO, 8'h55);
    `CHK("sda_oe", 1'b0, sda_oe)
    wr(BCR_ADDR_TWO, 8'h45);
    `CHK("sda_oe", 1'b1, sda_oe)
    rc(BCR_ADDR_TWO, 8'h30, 8'h10);
    wr(BCR_ADDR_ONE, 8'h00);
    `CHK("sda_oe", 1'b0, sda_oe)
    wr(BCR_ADDR_ONE, 8'h80);
    wr(BCR_ADDR_TWO, 8'h65);
    `CHK("sda_oe", 1'b0, sda_oe)
    `END("sda")
    wr(BCR_ADDR_ONE, 8'hB0);
    wr(BCR_ADDR_TWO, 8'h85);
    repeat (300) @(posedge aclk);
    rc(BCR_ADDR_TWO, 8'hC0, 8'hC0);
    wr(BCR_ADDR_TWO, 8'h25);
    repeat (300) @(posedge aclk);
    rc(BCR_ADDR_TWO, 8'h80, 8'h00);
    `CHK("sda_oe", 1'b0, sda_oe)
    wr(BCR_ADDR_TWO, 8'h7F);
    `CHK("crst", 1'b1, ctrl_reset)
    `CHK("bitcnt", BCR_BITCNT_RST, transfer_bit_counter)
    rc(BCR_ADDR_TWO, 8'h02, 8'h02);
    wr(BCR_ADDR_TWO, 8'h7D);
    `CHK("crst", 1'b0, ctrl_reset)
    `END("cond")
    sync_format <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      k = i == 2 ? 4'($random(seed)) : {i[0], 3'h0} | {1'b0, {3{i[0]}}};
      frame_active <= 1'b0;
      wr(BCR_ADDR_ONE, 8'hB0 | k);
      frame_active <= 1'b1;
      for (int j = 0; j < 2; j++) begin
        c = '0;
        while (scl_oe && c < 2000) begin
          @(posedge aclk);
          c++;
        end
        while (!scl_oe && c < 2000) begin
          @(posedge aclk);
          c++;
        end
      end
      if (c >= 2000) tmo();
      `CHK("period", div(k), c)
    end
    `END("divider")
    results();
  end
endmodule
bind bcr_ctrl bcr_ctrl_asserts chk (.*);
